// file: design/sbsc_defs.svh
// constants of the synchronous burst sram control port
// assumes inclusion by bare name from every design file that needs them
`ifndef SBSC_DEFS_SVH
`define SBSC_DEFS_SVH

`define SBSC_ADDR_W 17
`define SBSC_WORDS 131072
`define SBSC_LANES 4
`define SBSC_LANE_W 9
`define SBSC_BYTE_W 8
`define SBSC_WORD_W 36
`define SBSC_DQ_W 32
`define SBSC_HI_LSB 2
`define SBSC_ALL_LANES 4'hF
`define SBSC_NO_LANES 4'h0
`define SBSC_SEQ_ZERO 2'h0
`define SBSC_SEQ_ONE 2'h1
`define SBSC_SEQ_LAST 2'h3
`define SBSC_BUF_DEPTH 2
`define SBSC_ENTRY_W 57

`endif

// file: design/sbsc_pkg.sv
// types shared by the control port, its host model and its bench
// assumes sbsc_defs.svh is on the include path
`include "sbsc_defs.svh"
`default_nettype none

package sbsc_pkg;
  typedef logic [`SBSC_ADDR_W-1:0] sbsc_addr_t;
  typedef logic [`SBSC_LANES-1:0] sbsc_lanes_t;
  typedef logic [`SBSC_WORD_W-1:0] sbsc_word_t;
  typedef logic [1:0] sbsc_seq_t;
  // access state: deselected or inside a selected burst
  typedef enum logic {
    SBSC_DESEL,
    SBSC_BURST
  } sbsc_state_e;
endpackage

`default_nettype wire

// file: design/sbsc_pair_buf.sv
// two-entry buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`include "sbsc_defs.svh"
`default_nettype none

module sbsc_pair_buf #(
  parameter int WIDTH = `SBSC_ENTRY_W,
  parameter int DEPTH = `SBSC_BUF_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slot [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // honest full and empty from the occupancy count
  assign in_ready_o = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = slot[rd_ptr_reg];

  // pointers wrap at the depth
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // storage carries no reset: contents are qualified by the count
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      slot[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= step(wr_ptr_reg);
      if (pop) rd_ptr_reg <= step(rd_ptr_reg);
      count_reg <= (PW+1)'(count_reg + push - pop);
    end
  end
endmodule

`default_nettype wire

// file: design/sbsc_port.sv
// control and address front end of a 128k x 36 pipelined burst sram
// assumes all synchronous inputs are timed to sys_clk_i; the array is
// held here and written through a two-entry buffer
`include "sbsc_defs.svh"
`default_nettype none

module sbsc_port (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`SBSC_ADDR_W-1:0] addr_i,
  input wire logic processor_address_strobe_n_i,
  input wire logic controller_address_strobe_n_i,
  input wire logic burst_advance_n_i,
  input wire logic global_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic [`SBSC_LANES-1:0] byte_lane_select_n_i,
  input wire logic chip_select_first_n_i,
  input wire logic chip_select_second_i,
  input wire logic chip_select_third_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_i,
  input wire logic [31:0] dq_i,
  output logic [31:0] dq_o,
  output logic dq_oe_o,
  input wire logic [`SBSC_LANES-1:0] parity_io_i,
  output logic [`SBSC_LANES-1:0] parity_io_o,
  output logic parity_io_oe_o,
  output logic wr_ready_o
);
  sbsc_pkg::sbsc_word_t mem [0:`SBSC_WORDS-1];
  sbsc_pkg::sbsc_state_e state_reg;
  sbsc_pkg::sbsc_state_e state_next;
  logic [`SBSC_ADDR_W-1:`SBSC_HI_LSB] addr_hi_reg;
  sbsc_pkg::sbsc_seq_t start_reg;
  sbsc_pkg::sbsc_seq_t seq_reg;
  sbsc_pkg::sbsc_seq_t seq_next;
  sbsc_pkg::sbsc_addr_t rd_addr_reg;
  logic rd_pend_reg;
  logic out_valid_reg;
  sbsc_pkg::sbsc_word_t dout_reg;
  logic linear_reg;
  logic strap_taken_reg;

  // next address inside the four-word group in the strapped order
  function automatic sbsc_pkg::sbsc_seq_t burst_offset(
    input sbsc_pkg::sbsc_seq_t start,
    input sbsc_pkg::sbsc_seq_t seq,
    input logic linear
  );
    burst_offset = linear ? 2'(start + seq) : (start ^ seq);
  endfunction

  // strobe decode; sleep freezes every synchronous action except the strap capture and the read pipeline flags rd_pend_reg and out_valid_reg
  wire awake = ~sleep_request_i;
  wire proc_strobe = ~processor_address_strobe_n_i &
                     ~chip_select_first_n_i;
  wire ctrl_strobe = ~controller_address_strobe_n_i &
                     ~proc_strobe;
  wire load = awake & (proc_strobe | ctrl_strobe);
  wire selected = ~chip_select_first_n_i & chip_select_second_i &
                  ~chip_select_third_n_i;
  wire capture = load & selected;
  wire deselect = load & ~selected;
  wire cont = awake & ~load &
              (state_reg == sbsc_pkg::SBSC_BURST);
  wire access = capture | cont;

  // write lane decode: global write overrides the byte path
  wire [`SBSC_LANES-1:0] byte_lanes = byte_write_enable_n_i ?
    `SBSC_NO_LANES : ~byte_lane_select_n_i;
  wire [`SBSC_LANES-1:0] lanes = global_write_n_i ? byte_lanes :
    `SBSC_ALL_LANES;
  wire is_write = access & (lanes != `SBSC_NO_LANES);
  wire is_read = access & (lanes == `SBSC_NO_LANES);

  // burst counter: load on capture, step on advance, wrap at four
  wire [1:0] start_now = capture ? addr_i[1:0] : start_reg;
  assign seq_next = load ? `SBSC_SEQ_ZERO :
    (cont & ~burst_advance_n_i) ? 2'(seq_reg + `SBSC_SEQ_ONE) :
    seq_reg;
  wire [`SBSC_ADDR_W-1:`SBSC_HI_LSB] hi_now = capture ?
    addr_i[`SBSC_ADDR_W-1:`SBSC_HI_LSB] : addr_hi_reg;
  wire [`SBSC_ADDR_W-1:0] cur_addr = {hi_now,
    burst_offset(start_now, seq_next, linear_reg)};

  // state follows the last address load
  assign state_next = capture ? sbsc_pkg::SBSC_BURST :
    deselect ? sbsc_pkg::SBSC_DESEL : state_reg;

  // write entries wait in the buffer; the array drains it when awake
  wire [`SBSC_WORD_W-1:0] wr_word = {parity_io_i, dq_i};
  wire [`SBSC_ENTRY_W-1:0] push_entry = {cur_addr, lanes, wr_word};
  wire [`SBSC_ENTRY_W-1:0] drain_entry;
  wire drain_valid;
  wire buf_ready;
  wire drain_ready = awake;
  wire push_valid = is_write;
  assign wr_ready_o = buf_ready;

  sbsc_pair_buf #(
    .WIDTH(`SBSC_ENTRY_W),
    .DEPTH(`SBSC_BUF_DEPTH)
  ) u_wbuf (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push_valid),
    .in_ready_o(buf_ready),
    .in_data_i(push_entry),
    .out_valid_o(drain_valid),
    .out_ready_i(drain_ready),
    .out_data_o(drain_entry)
  );

  wire [`SBSC_ADDR_W-1:0] drain_addr =
    drain_entry[`SBSC_ENTRY_W-1:`SBSC_ENTRY_W-`SBSC_ADDR_W];
  wire [`SBSC_LANES-1:0] drain_lanes =
    drain_entry[`SBSC_WORD_W+`SBSC_LANES-1:`SBSC_WORD_W];
  wire [`SBSC_WORD_W-1:0] drain_word = drain_entry[`SBSC_WORD_W-1:0];

  // lane i is byte i of dq plus parity bit i; word layout is {par, dq}
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < `SBSC_LANES; i++) begin
      if (drain_valid & drain_ready & drain_lanes[i]) begin
        mem[drain_addr][i*`SBSC_BYTE_W +: `SBSC_BYTE_W] <=
          drain_word[i*`SBSC_BYTE_W +: `SBSC_BYTE_W];
        mem[drain_addr][`SBSC_DQ_W+i] <= drain_word[`SBSC_DQ_W+i];
      end
    end
  end

  // output register: loads one edge after the read was captured
  always_ff @(posedge sys_clk_i) begin
    if (rd_pend_reg & awake) begin
      dout_reg <= mem[rd_addr_reg];
    end
  end

  // strap is caught by the first clock after reset release
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      linear_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      linear_reg <= ~burst_order_i;
      strap_taken_reg <= 1'b1;
    end
  end

  // address, counter and pipeline control
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= sbsc_pkg::SBSC_DESEL;
      addr_hi_reg <= '0;
      start_reg <= `SBSC_SEQ_ZERO;
      seq_reg <= `SBSC_SEQ_ZERO;
      rd_addr_reg <= '0;
      rd_pend_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      seq_reg <= seq_next;
      if (capture) begin
        addr_hi_reg <= hi_now;
        start_reg <= addr_i[1:0];
      end
      rd_addr_reg <= cur_addr;
      rd_pend_reg <= is_read;
      out_valid_reg <= awake & ~deselect & rd_pend_reg;
    end
  end

  // pin direction: asynchronous output enable gates registered data;
  // a fresh read leaves out_valid low for its first clock
  wire drive = out_valid_reg & ~output_enable_n_i &
               awake;
  assign dq_oe_o = drive;
  assign parity_io_oe_o = drive;
  // zero when idle so a stale word never sits on the output lines
  assign dq_o = out_valid_reg ? dout_reg[`SBSC_DQ_W-1:0] : '0;
  assign parity_io_o = out_valid_reg ?
    dout_reg[`SBSC_WORD_W-1:`SBSC_DQ_W] : `SBSC_NO_LANES;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_addr_capture: assert property (capture |=>
    addr_hi_reg == $past(addr_i[`SBSC_ADDR_W-1:`SBSC_HI_LSB]))
    else $error("address not captured on selected strobe");
  a_counter_load: assert property (capture |=>
    start_reg == $past(addr_i[1:0]) && seq_reg == `SBSC_SEQ_ZERO)
    else $error("burst counter not loaded from low address");
  a_byte_qual: assert property (push_valid && global_write_n_i |->
    !byte_write_enable_n_i && lanes == ~byte_lane_select_n_i)
    else $error("byte write without byte-write enable");
  a_global_all: assert property (access && !global_write_n_i |->
    push_valid && push_entry[`SBSC_WORD_W+`SBSC_LANES-1:`SBSC_WORD_W]
    == `SBSC_ALL_LANES)
    else $error("global write did not select every lane");
  a_burst_hold: assert property (cont && burst_advance_n_i |=>
    $stable(seq_reg))
    else $error("burst counter moved without advance");
  a_burst_wrap: assert property (cont && !burst_advance_n_i &&
    seq_reg == `SBSC_SEQ_LAST |=> seq_reg == `SBSC_SEQ_ZERO)
    else $error("burst counter did not wrap");
  a_select_decode: assert property (load && !selected |=>
    state_reg == sbsc_pkg::SBSC_DESEL && !dq_oe_o)
    else $error("device stayed selected on bad chip selects");
  a_proc_ignored: assert property (chip_select_first_n_i &&
    controller_address_strobe_n_i |-> !load)
    else $error("processor strobe acted with first select high");
  a_strobe_prio: assert property (proc_strobe |-> !ctrl_strobe)
    else $error("controller strobe acted beside processor strobe");
  a_burst_ignores_cs: assert property (cont && !selected |=>
    state_reg == sbsc_pkg::SBSC_BURST)
    else $error("chip selects evaluated during burst");
  a_first_tristate: assert property (
    state_reg == sbsc_pkg::SBSC_DESEL && capture && is_read |=>
    !dq_oe_o)
    else $error("pins driven in first clock after deselect");
  a_read_latency: assert property (is_read && awake |=> ##1
    out_valid_reg || $past(deselect) || $past(sleep_request_i))
    else $error("read data not registered one edge after capture");
  a_oe_direction: assert property (dq_oe_o |->
    !output_enable_n_i && out_valid_reg)
    else $error("data pins driven while output enable high");
  a_sleep_idle: assert property (sleep_request_i |->
    !load && !push_valid && !dq_oe_o)
    else $error("activity while sleep requested");
  a_read_kind: assert property (capture && global_write_n_i &&
    byte_write_enable_n_i |=> rd_pend_reg)
    else $error("capture without write inputs not a read");

  // address and counter registers move only when they should
  a_hi_hold: assert property (!capture |=>
    $stable(addr_hi_reg))
    else $error("address register moved without capture");
  a_start_hold: assert property (!capture |=>
    $stable(start_reg))
    else $error("burst start moved without capture");
  a_counter_step: assert property (cont && !burst_advance_n_i |=>
    seq_reg == 2'($past(seq_reg) + `SBSC_SEQ_ONE))
    else $error("burst counter did not step on advance");
  a_strap_static: assert property (strap_taken_reg |=>
    $stable(linear_reg))
    else $error("burst order changed during operation");

  // strobe priority seen from the controller side
  a_ctrl_acts: assert property (awake &&
    !controller_address_strobe_n_i && processor_address_strobe_n_i |-> load)
    else $error("controller strobe alone did not load");

  // pin direction and idle levels
  a_oe_async: assert property (output_enable_n_i |-> !dq_oe_o)
    else $error("data pins driven with output enable high");
  a_parity_dir: assert property (parity_io_oe_o == dq_oe_o)
    else $error("parity and data directions differ");
  a_idle_zero: assert property (!out_valid_reg |->
    dq_o == '0 && parity_io_o == `SBSC_NO_LANES)
    else $error("output lines not zero without data");
  a_desel_float: assert property (deselect |=>
    !out_valid_reg && !dq_oe_o)
    else $error("outputs not tristated after deselect");

  // sleep freezes state; the write buffer can never overflow when awake
  a_sleep_hold: assert property (sleep_request_i |=>
    $stable(seq_reg) && $stable(state_reg))
    else $error("burst state moved during sleep");
  a_buffer_room: assert property (push_valid |-> wr_ready_o)
    else $error("write pushed into a full buffer");

  c_sleep_wake: cover property (sleep_request_i ##1
    !sleep_request_i ##1 capture);
  c_full_burst: cover property (capture && is_read ##1
    (cont && !burst_advance_n_i) [*3]);
  c_global_write: cover property (capture && !global_write_n_i);
  c_byte_write: cover property (push_valid && global_write_n_i);
  c_buffer_full: cover property (!wr_ready_o && sleep_request_i);
endmodule

`default_nettype wire

// file: tb/sbsc_host.sv
// bus-side partner: processor or cache controller driving the port
// assumes the bench calls step once per cycle, right after a rising edge
`include "sbsc_defs.svh"
`default_nettype none

module sbsc_host (
  input wire logic sys_clk_i,
  output var sbsc_pkg::sbsc_addr_t addr_o,
  output var logic psn_o,
  output var logic csn_o,
  output var logic adv_o,
  output var logic gw_o,
  output var logic bwe_o,
  output var logic [3:0] lanes_o,
  output var logic cs1n_o,
  output var logic cs2_o,
  output var logic cs3n_o,
  output var logic [31:0] dq_o,
  output var logic [3:0] par_o,
  output var logic rd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // lane i is {parity bit i, data byte i}
  function automatic logic [31:0] dq_of(input sbsc_pkg::sbsc_word_t w);
    for (int i = 0; i < 4; i++) dq_of[8*i+:8] = w[9*i+:8];
  endfunction

  function automatic logic [3:0] par_of(input sbsc_pkg::sbsc_word_t w);
    for (int i = 0; i < 4; i++) par_of[i] = w[9*i+8];
  endfunction

  // idle bus at time zero: strobes high, chip not selected
  initial begin
    {psn_o, csn_o, adv_o, gw_o, bwe_o} = 5'h1F;
    lanes_o = 4'hF;
    {cs1n_o, cs2_o, cs3n_o} = 3'h5;
    addr_o = 17'h00000;
    dq_o = 32'h00000000;
    par_o = 4'h0;
    rd_o = 1'b0;
  end

  // one cycle: change after the fall, hold through the next rise
  task automatic step(input logic [1:0] strb, input sbsc_pkg::sbsc_addr_t a,
      input logic [2:0] wr, input logic [3:0] ln, input logic sel,
      input sbsc_pkg::sbsc_word_t w, input logic chk);
    @(negedge sys_clk_i);
    {psn_o, csn_o} = strb;
    addr_o = a;
    {gw_o, bwe_o, adv_o} = wr;
    lanes_o = ln;
    {cs1n_o, cs2_o, cs3n_o} = sel ? 3'h2 : 3'h5;
    rd_o = chk;
    if (wr[2] & wr[1]) begin
      // no write: flip the lines so stale data never looks valid
      dq_o = ~dq_o;
      par_o = ~par_o;
    end else begin
      dq_o = dq_of(w);
      par_o = par_of(w);
    end
    @(posedge sys_clk_i);
  endtask
endmodule

`default_nettype wire

// file: tb/sync_burst_sram_control_port_tb_top.sv
// self-checking bench for the burst sram control port
// assumes sbsc_host drives the bus; reads are scored through a queue
`include "sbsc_defs.svh"
`default_nettype none

module sync_burst_sram_control_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic oe_n = 1'b0;
  logic sleep = 1'b0;
  logic order = 1'b0;
  sbsc_pkg::sbsc_addr_t addr;
  logic psn, csn, burst_advance_n, gw, byte_write_enable_n, cs1n, cs2, cs3n, rd, dq_oe, par_oe, wr_rdy;
  logic [3:0] lanes, parw, par_o;
  logic [31:0] dqw, dq_o;
  sbsc_pkg::sbsc_word_t mem [int];
  sbsc_pkg::sbsc_word_t expq [$];
  logic [1:0] pipe = 2'h0;
  int miscompares = 0;
  int checks_done = 0;

  sbsc_host host (.sys_clk_i(sys_clk_i), .addr_o(addr), .psn_o(psn),
    .csn_o(csn), .adv_o(burst_advance_n), .gw_o(gw), .bwe_o(byte_write_enable_n), .lanes_o(lanes),
    .cs1n_o(cs1n), .cs2_o(cs2), .cs3n_o(cs3n), .dq_o(dqw), .par_o(parw),
    .rd_o(rd));

  sbsc_port dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .processor_address_strobe_n_i(psn),
    .controller_address_strobe_n_i(csn), .burst_advance_n_i(burst_advance_n),
    .global_write_n_i(gw), .byte_write_enable_n_i(byte_write_enable_n),
    .byte_lane_select_n_i(lanes), .chip_select_first_n_i(cs1n),
    .chip_select_second_i(cs2), .chip_select_third_n_i(cs3n),
    .output_enable_n_i(oe_n), .sleep_request_i(sleep),
    .burst_order_i(order), .dq_i(dqw), .dq_o(dq_o), .dq_oe_o(dq_oe),
    .parity_io_i(parw), .parity_io_o(par_o), .parity_io_oe_o(par_oe),
    .wr_ready_o(wr_rdy));

  initial forever #25 sys_clk_i = ~sys_clk_i;

  task automatic print_verdict();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic cmp_word(input sbsc_pkg::sbsc_word_t exp);
    checks_done++;
    if (dq_o !== host.dq_of(exp) || par_o !== host.par_of(exp)) begin
      miscompares++;
      $display("[FAIL] %0t read word %h", $time, exp);
    end
  endtask

  // burst offset: interleaved xor, linear add with two-bit wrap
  function automatic logic [1:0] off(input logic o, input logic [1:0] s, k);
    return o ? s ^ k : 2'(s + k);
  endfunction

  // a read shows its data one rise later, so score two rises behind
  always @(posedge sys_clk_i) pipe <= {pipe[0], rd};
  always @(negedge sys_clk_i) begin
    if (pipe[1] === 1'b1 && expq.size() > 0) begin
      cmp_word(expq.pop_front());
      cmp_bit(dq_oe, !oe_n, "data drive");
      cmp_bit(par_oe, !oe_n, "parity drive");
    end
  end

  task automatic desel();
    host.step(2'h2, 17'h00000, 3'h7, 4'hF, 1'b0, '0, 1'b0);
  endtask

  task automatic run_pass(input logic o, input logic e);
    sbsc_pkg::sbsc_addr_t g;
    sbsc_pkg::sbsc_word_t w;
    logic [1:0] s;
    logic [3:0] ln;
    g = sbsc_pkg::sbsc_addr_t'($urandom) & 17'h1FFFC;
    s = 2'($urandom);
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    order = o;
    oe_n = e;
    repeat (20) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    cmp_bit(wr_rdy, 1'b1, "buffer room after reset");
    cmp_bit(dq_oe, 1'b0, "pins idle after reset");
    // write burst; lanes and byte enable must not matter
    for (int k = 0; k < 4; k++) begin
      w = {$urandom, 4'($urandom)};
      host.step(k ? 2'h3 : 2'h2, g | 17'(s), {1'b0, 1'($urandom), k == 0},
        4'($urandom), k ? 1'($urandom) : 1'b1, w,
        1'b0);
      mem[g | 17'(off(o, s, 2'(k)))] = w;
    end
    desel();
    s = 2'($urandom);
    ln = 4'($urandom);
    w = {$urandom, 4'($urandom)};
    host.step(2'h1, g | 17'(s), 3'h5, ln, 1'b1, w,
      1'b0);
    for (int i = 0; i < 4; i++) begin
      if (!ln[i]) mem[g | 17'(s)][9*i+:9] = w[9*i+:9];
    end
    desel();
    desel();
    // burst read from a deselected state, both strobes low
    s = 2'($urandom);
    host.step(2'h0, g | 17'(s), 3'h7, 4'($urandom), 1'b1, '0,
      1'b1);
    #5 cmp_bit(dq_oe, 1'b0, "first read cycle drive");
    expq.push_back(mem[g | 17'(s)]);
    // processor strobe with first select high must not restart the burst
    for (int k = 1; k < 4; k++) begin
      host.step(k == 2 ? 2'h1 : 2'h3, k == 2 ? ~g : g, 3'h6, 4'($urandom),
        1'b0, '0, 1'b1);
      expq.push_back(mem[g | 17'(off(o, s, 2'(k)))]);
    end
    host.step(2'h3, g, 3'h7, 4'hF, 1'b1, '0, 1'b0);
    desel();
    // writes while asleep or while not selected are dropped
    @(negedge sys_clk_i);
    sleep = 1'b1;
    host.step(2'h2, g | 17'(s), 3'h1, 4'h0, 1'b1, ~mem[g | 17'(s)], 1'b0);
    cmp_bit(dq_oe, 1'b0, "pins idle in sleep");
    // idle the bus while still asleep, else the write lands on waking
    desel();
    @(negedge sys_clk_i);
    sleep = 1'b0;
    host.step(2'h2, g | 17'(s), 3'h1, 4'h0, 1'b0, ~mem[g | 17'(s)],
      1'b0);
    desel();
    host.step(2'h2, g | 17'(s), 3'h7, 4'hF, 1'b1, '0,
      1'b1);
    expq.push_back(mem[g | 17'(s)]);
    host.step(2'h3, g, 3'h7, 4'hF, 1'b1, '0, 1'b0);
    desel();
    desel();
  endtask

  initial begin
    void'($urandom(48448));
    // four passes take some 200 cycles; ten times that means a hang
    fork
      begin
        repeat (2000) @(posedge sys_clk_i);
        miscompares++;
        print_verdict();
      end
    join_none
    for (int p = 0; p < 4; p++) run_pass(p[0], p[1]);
    print_verdict();
  end
endmodule

`default_nettype wire
